/* File: rtl/rfrd_pkg.sv */
// Shared constants and types for the reader tag access logic
package rfrd_pkg;

   // ===========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int CARRIER_PERIOD_NS = 8000;
   localparam int CARRIER_CYC = (CARRIER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_NS = 1000;
   localparam int SAMPLE_CYC = SAMPLE_NS / CLK_PERIOD_NS;
   localparam int LAT_LP0_US = 310;
   localparam int LAT_LP1_US = 175;
   localparam int DLY_DEPTH = 512;
   localparam int DLY_AW = 9;

   // ===========================================================
   // Serial command codes
   localparam logic [2:0] CMD_READ_TAG = 3'h7;
   localparam logic [2:0] CMD_QUICK_WRITE = 3'h6;
   localparam logic [3:0] CMD_TIMED_PFX = 4'h1;
   localparam logic [1:0] CMD_CFG_PFX = 2'h1;
   localparam logic [3:0] SHORT_CMD_BITS = 4'h3;
   localparam logic [3:0] LONG_CMD_BITS = 4'h8;
   localparam logic [1:0] CFG_PAGE0 = 2'h0;
   localparam logic [1:0] CFG_PAGE2 = 2'h2;
   localparam logic [3:0] PULSE_LEN_RESET = 4'h0;

   // ===========================================================
   // Configuration field positions
   localparam int P0_LOWPASS_BIT = 0;
   localparam int P0_HIGHPASS_BIT = 1;
   localparam int P2_ACCEL_LO_BIT = 0;
   localparam int P2_ACCEL_HI_BIT = 1;
   localparam int P2_THR_TRACK_BIT = 3;

   // ===========================================================
   // Highpass time constant divisors
   localparam logic [4:0] HP_DIV_NORMAL = 5'h01;
   localparam logic [4:0] HP_DIV_SEL0 = 5'h10;
   localparam logic [4:0] HP_DIV_SEL1 = 5'h08;

   // ===========================================================
   // Register map (byte addresses)
   localparam logic [7:0] REG_CFG0 = 8'h00;
   localparam logic [7:0] REG_CFG2 = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [3:0] CFG_RESET = 4'h0;

   // ===========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_READ,
      MODE_WRITE
   } rfrd_mode_e;

   typedef struct packed {
      logic lp_freeze;
      logic hp_quiet_ground;
      logic [4:0] hp_tc_div;
      logic hp2_quiet_ground;
      logic threshold_track;
   } rfrd_filt_s;

endpackage

/* File: rtl/rfrd_sync.sv */
// Two-stage synchroniser with rising edge detect for one pin
`timescale 1ns/10ps
module rfrd_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin and synchronised view
   input wire logic async_i,
   output logic level_o,
   output logic rise_o
);
   logic meta;
   logic stage;
   logic prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         stage <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= async_i;
         stage <= meta;
         prev <= stage;
      end
   end

   assign level_o = stage;
   assign rise_o = stage & ~prev;
endmodule

/* File: rtl/rfrd_pulse_timer.sv */
// Write pulse generator: timed in carrier periods or following the data pin
`timescale 1ns/10ps
module rfrd_pulse_timer
   import rfrd_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic [3:0] len_i,
   input wire logic level_i,
   // Pulse
   output logic pulse_o
);
   localparam logic [9:0] DIV_LAST = 10'(CARRIER_CYC - 1);

   logic [9:0] div;
   logic [3:0] ticks;
   wire div_wrap = (div == DIV_LAST);
   wire last_tick = (ticks == len_i - 4'h1);

   always_ff @(posedge clk_i) begin
      if (rst_i || abort_i) begin
         pulse_o <= 1'b0;
         div <= 10'h000;
         ticks <= 4'h0;
      end else if (start_i && !pulse_o) begin
         pulse_o <= 1'b1;
         div <= 10'h000;
         ticks <= 4'h0;
      end else if (pulse_o) begin
         if (len_i == 4'h0) begin
            pulse_o <= level_i;
         end else if (div_wrap) begin
            div <= 10'h000;
            ticks <= ticks + 4'h1;
            if (last_tick) begin
               pulse_o <= 1'b0;
            end
         end else begin
            div <= div + 10'h001;
         end
      end
   end

   // Timed pulses never outlast the programmed number of carrier periods
   timed_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pulse_o && len_i != 4'h0 |-> ticks < len_i)
      else $error("timed pulse exceeded its length");
   // Start with no abort raises the pulse on the next edge
   pulse_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      start_i && !pulse_o && !abort_i |=> pulse_o)
      else $error("write pulse did not start");
endmodule

/* File: rtl/rfrd_access.sv */
// Reader command interpreter: transparent read, tag write pulses, settling control
`timescale 1ns/10ps
module rfrd_access
   import rfrd_pkg::*;
#(
   parameter int LAT0_US = LAT_LP0_US,
   parameter int LAT1_US = LAT_LP1_US
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial interface pins
   input wire logic sclk_i,
   input wire logic din_i,
   output logic dout_o,
   // Front end
   input wire logic demod_i,
   output logic drv_on_o,
   output rfrd_filt_s filt_o
);
   localparam logic [DLY_AW-1:0] DLY0 = DLY_AW'(LAT0_US * 1000 / SAMPLE_NS);
   localparam logic [DLY_AW-1:0] DLY1 = DLY_AW'(LAT1_US * 1000 / SAMPLE_NS);
   localparam logic [6:0] SAMPLE_LAST = 7'(SAMPLE_CYC - 1);

   // ===========================================================
   // Pin synchronisers
   logic sclk_lvl;
   logic sclk_rise;
   logic din_lvl;
   logic din_rise;
   logic demod_lvl;

   rfrd_sync u_sclk_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(sclk_i),
      .level_o(sclk_lvl),
      .rise_o(sclk_rise)
   );
   rfrd_sync u_din_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(din_i),
      .level_o(din_lvl),
      .rise_o(din_rise)
   );
   rfrd_sync u_demod_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(demod_i),
      .level_o(demod_lvl),
      .rise_o()
   );

   // ===========================================================
   // Serial command receiver
   rfrd_mode_e mode;
   logic [7:0] shreg;
   logic [3:0] bitcnt;
   logic [3:0] stored_len;
   logic [3:0] active_len;
   logic [3:0] cfg0;
   logic [3:0] cfg2;

   wire in_idle = (mode == MODE_IDLE);
   wire shift_en = sclk_rise & in_idle;
   // Data rising while clock is high restarts command framing
   wire frame_reset = din_rise & sclk_lvl & in_idle;
   wire [7:0] next_shreg = {shreg[6:0], din_lvl};
   wire [3:0] next_cnt = bitcnt + 4'h1;
   wire short_done = shift_en & (next_cnt == SHORT_CMD_BITS);
   wire long_done = shift_en & (next_cnt == LONG_CMD_BITS);
   wire cmd_read = short_done & (next_shreg[2:0] == CMD_READ_TAG);
   wire cmd_quick = short_done & (next_shreg[2:0] == CMD_QUICK_WRITE);
   wire cmd_timed = long_done & (next_shreg[7:4] == CMD_TIMED_PFX);
   wire cmd_cfg = long_done & (next_shreg[7:6] == CMD_CFG_PFX);
   wire cfg0_cmd = cmd_cfg & (next_shreg[5:4] == CFG_PAGE0);
   wire cfg2_cmd = cmd_cfg & (next_shreg[5:4] == CFG_PAGE2);
   wire mode_exit = sclk_rise & ~in_idle;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= MODE_IDLE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         stored_len <= PULSE_LEN_RESET;
         active_len <= PULSE_LEN_RESET;
      end else if (mode_exit) begin
         mode <= MODE_IDLE;
         bitcnt <= 4'h0;
      end else if (frame_reset) begin
         bitcnt <= 4'h0;
         shreg <= 8'h00;
      end else if (shift_en) begin
         shreg <= next_shreg;
         bitcnt <= (long_done || cmd_read || cmd_quick) ? 4'h0 : next_cnt;
         if (cmd_read) begin
            mode <= MODE_READ;
         end else if (cmd_quick) begin
            mode <= MODE_WRITE;
            active_len <= stored_len;
         end else if (cmd_timed) begin
            mode <= MODE_WRITE;
            stored_len <= next_shreg[3:0];
            active_len <= next_shreg[3:0];
         end
      end
   end

   // ===========================================================
   // Configuration pages, written by command or by software
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
   wire sel_cfg0 = (wb_adr_i == REG_CFG0);
   wire sel_cfg2 = (wb_adr_i == REG_CFG2);
   wire sel_status = (wb_adr_i == REG_STATUS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg0 <= CFG_RESET;
         cfg2 <= CFG_RESET;
      end else begin
         if (cfg0_cmd) begin
            cfg0 <= next_shreg[3:0];
         end else if (wb_wr && sel_cfg0) begin
            cfg0 <= wb_dat_i[3:0];
         end
         if (cfg2_cmd) begin
            cfg2 <= next_shreg[3:0];
         end else if (wb_wr && sel_cfg2) begin
            cfg2 <= wb_dat_i[3:0];
         end
      end
   end

   // ===========================================================
   // Wishbone read side; unmapped addresses read zero
   wire [31:0] status_word = {24'h000000, stored_len, 1'b0, drv_on_o, mode};
   wire [31:0] rd_mux = sel_cfg0 ? {28'h0000000, cfg0} :
                        sel_cfg2 ? {28'h0000000, cfg2} :
                        sel_status ? status_word : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : 32'h00000000;
      end
   end

   // ===========================================================
   // Settling acceleration decode
   wire lowpass_select = cfg0[P0_LOWPASS_BIT];
   wire highpass_select = cfg0[P0_HIGHPASS_BIT];
   wire settle_accel_lo = cfg2[P2_ACCEL_LO_BIT];
   wire settle_accel_hi = cfg2[P2_ACCEL_HI_BIT];
   wire threshold_track = cfg2[P2_THR_TRACK_BIT];
   wire [4:0] hp_fast_div = highpass_select ? HP_DIV_SEL1 : HP_DIV_SEL0;
   rfrd_filt_s next_filt;

   assign next_filt.lp_freeze = settle_accel_lo ^ settle_accel_hi;
   assign next_filt.hp_quiet_ground = settle_accel_lo & ~settle_accel_hi;
   assign next_filt.hp_tc_div = settle_accel_hi ? hp_fast_div : HP_DIV_NORMAL;
   assign next_filt.hp2_quiet_ground = settle_accel_lo & settle_accel_hi;
   assign next_filt.threshold_track = threshold_track;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filt_o <= '0;
      end else begin
         filt_o <= next_filt;
      end
   end

   // ===========================================================
   // Read path delay line, sampled every microsecond
   // Ring of single bits keeps the long latency cheap in area
   logic dly_mem [DLY_DEPTH];
   logic [DLY_AW-1:0] wptr;
   logic [6:0] sample_cnt;
   logic dly_bit;
   wire sample_tick = (sample_cnt == SAMPLE_LAST);
   wire [DLY_AW-1:0] dly_sel = lowpass_select ? DLY1 : DLY0;
   wire [DLY_AW-1:0] rptr = wptr - dly_sel;

   always_ff @(posedge clk_i) begin
      if (sample_tick) begin
         dly_mem[wptr] <= demod_lvl;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr <= '0;
         sample_cnt <= 7'h00;
         dly_bit <= 1'b0;
      end else begin
         sample_cnt <= sample_tick ? 7'h00 : sample_cnt + 7'h01;
         if (sample_tick) begin
            wptr <= wptr + 9'h001;
            dly_bit <= dly_mem[rptr];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dout_o <= 1'b0;
      end else begin
         dout_o <= (mode == MODE_READ) & dly_bit;
      end
   end

   // ===========================================================
   // Write pulses and antenna drivers
   logic pulse_on;
   wire in_write = (mode == MODE_WRITE);

   rfrd_pulse_timer u_pulse (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(in_write & din_rise & ~sclk_rise),
      .abort_i(mode_exit | ~in_write),
      .len_i(active_len),
      .level_i(din_lvl),
      .pulse_o(pulse_on)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drv_on_o <= 1'b1;
      end else begin
         drv_on_o <= ~pulse_on;
      end
   end

   // ===========================================================
   // Checks
   read_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_read && !mode_exit |=> mode == MODE_READ ##1 dout_o == $past(dly_bit))
      else $error("read mode not entered");
   read_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mode == MODE_READ && sclk_rise |=> mode == MODE_IDLE ##1 !dout_o)
      else $error("read mode not left on clock edge");
   write_cut_a: assert property (@(posedge clk_i) disable iff (rst_i)
      in_write && sclk_rise |=> !pulse_on ##1 drv_on_o)
      else $error("write mode not ended at once");
   drv_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      drv_on_o == !$past(pulse_on))
      else $error("drivers not tracking write pulse");
   quick_arg_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_quick && !mode_exit |=> in_write && active_len == $past(stored_len))
      else $error("quick write lost stored length");
   transp_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
      in_write && active_len == 4'h0 && pulse_on && !din_lvl |=> !pulse_on)
      else $error("transparent pulse outlived data high");
   latency_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wptr - rptr == (lowpass_select ? DLY_AW'(LAT1_US) : DLY_AW'(LAT0_US)))
      else $error("wrong read latency selected");
   accel_lo_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg2_cmd && next_shreg[1:0] == 2'h1 |=> ##1 filt_o.lp_freeze
      && filt_o.hp_quiet_ground && filt_o.hp_tc_div == HP_DIV_NORMAL)
      else $error("low accel setting not applied");
   accel_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
      settle_accel_hi && !highpass_select |=> filt_o.hp_tc_div == 5'h10)
      else $error("highpass divide not applied");
   thr_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(threshold_track) |=> filt_o.threshold_track)
      else $error("threshold track not applied");
endmodule

/* File: testbench/rfrd_host_model.sv */
// Host controller model driving the reader serial pins
`timescale 1ns/10ps
module rfrd_host_model (
   // Serial pins toward the reader
   output logic sclk_o,
   output logic din_o
);
   localparam realtime HALF = 62.5;
   // No power-down and no phase reads here, so no field settling wait
   initial begin
      sclk_o = 1'b0;
      din_o = 1'b0;
   end
   // ==========================================
   // Command framing
   task automatic send(input logic [7:0] v, input int n);
      din_o = 1'b0;
      #HALF sclk_o = 1'b1;
      #HALF din_o = 1'b1;
      #HALF sclk_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #HALF din_o = v[i];
         #HALF sclk_o = 1'b1;
         #HALF sclk_o = 1'b0;
      end
      // Clock then rests low for the whole mode
      #HALF din_o = 1'b0;
   endtask
   // ==========================================
   // Write gaps and mode exit
   task automatic pulse(input realtime hi);
      din_o = 1'b1;
      #hi din_o = 1'b0;
   endtask
   // Called only once the last gap has run out, unless cutting on purpose
   task automatic leave();
      sclk_o = 1'b1;
      #HALF sclk_o = 1'b0;
      #HALF;
   endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the reader command interpreter
`timescale 1ns/10ps
module tb_top;
   import rfrd_pkg::*;
   localparam int LAT0 = 10;
   localparam int LAT1 = 5;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic sclk;
   logic din;
   logic dout_o;
   logic demod_i = 1'b0;
   logic drv_on_o;
   rfrd_filt_s filt_o;
   rfrd_filt_s e;
   logic [31:0] exp_q[$];
   int bad_count = 0;
   int samples_checked = 0;
   int n;
   int h_t;
   logic [3:0] len;
   logic tt;

   always #5 clk_i = ~clk_i;

   rfrd_access #(.LAT0_US(LAT0), .LAT1_US(LAT1)) rfrd_access_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .sclk_i(sclk), .din_i(din), .dout_o(dout_o), .demod_i(demod_i),
      .drv_on_o(drv_on_o), .filt_o(filt_o));

   rfrd_host_model host (.sclk_o(sclk), .din_o(din));

   // ==========================================
   // Comparison and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
      logic ok;
      samples_checked++;
      ok = (seen === exp);
      if (tol > 0) begin
         ok = (^seen !== 1'bx) && (seen + tol >= exp) && (seen <= exp + tol);
      end
      if (!ok) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Read data is judged at the acknowledge edge against the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         check(wb_dat_o, exp_q.pop_front(), 0);
      end
   end

   // ==========================================
   // Bus and gap helpers
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      if (!we) exp_q.push_back(d);
      // Only the watchdog ends a wait for the acknowledge
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Length of one driver-off gap, in clocks
   task automatic gap(input realtime hi, output int g);
      int t;
      t = 0;
      g = 0;
      fork
         host.pulse(hi);
         begin
            while (drv_on_o !== 1'b0 && t < 100) begin
               @(posedge clk_i);
               t++;
            end
            while (drv_on_o === 1'b0 && g < 20000) begin
               @(posedge clk_i);
               g++;
            end
         end
      join
   endtask

   initial begin
      #900_000;
      bad_count++;
      finish_test();
   end

   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(36));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // Free-running bench clock: no oscillator settling wait is owed
      repeat (5) @(posedge clk_i);
      check(drv_on_o, 1, 0);
      wb(0, REG_CFG0, 32'h0);
      wb(0, REG_STATUS, 32'h04);
      wb(0, 8'h0c, 32'h0);
      // Quick write before any timed write: transparent
      host.send(8'h06, 3);
      wb(0, REG_STATUS, 32'h06);
      // Two or three carrier periods off give the shortest full-depth gap
      h_t = (2 + $urandom % 2) * CARRIER_CYC;
      gap(h_t * 10.0, n);
      check(n, h_t, 3);
      host.leave();
      // Timed gaps, two in a row, then reuse by quick write
      len = 4'(1 + $urandom % 15);
      host.send({4'h1, len}, 8);
      repeat (2) begin
         gap(1000.0, n);
         check(n, len * 800, 3);
      end
      host.leave();
      wb(0, REG_STATUS, {24'h0, len, 4'h4});
      host.send(8'h06, 3);
      gap(1000.0, n);
      check(n, len * 800, 3);
      // Clock edge in mid-gap cuts it short
      fork
         host.pulse(1000.0);
         begin
            #2000;
            host.leave();
         end
      join
      repeat (12) @(posedge clk_i);
      check(drv_on_o, 1, 0);
      wb(0, REG_STATUS, {24'h0, len, 4'h4});
      // Argument zero: gap follows data high time
      host.send(8'h10, 8);
      h_t = 300 + $urandom % 400;
      gap(h_t * 10.0, n);
      check(n, h_t, 3);
      host.leave();
      // Transparent read with both lowpass settings
      for (int lp = 0; lp < 2; lp++) begin
         wb(1, REG_CFG0, {31'h0, lp[0]});
         host.send(8'h07, 3);
         wb(0, REG_STATUS, 32'h05);
         // Let old samples drain from the delay line before the data edge
         repeat ((lp ? LAT1 : LAT0) * 100 + 300) @(posedge clk_i);
         demod_i <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (dout_o !== 1'b1 && n < 5000);
         // Two sync stages, sample phase 0 to 99, one output register
         check(n, (lp ? LAT1 : LAT0) * SAMPLE_CYC + 55, 50);
         demod_i <= 1'b0;
         host.leave();
         repeat (8) @(posedge clk_i);
         check(dout_o, 0, 0);
         wb(0, REG_STATUS, 32'h04);
      end
      // Settling controls for every code and highpass setting
      for (int h = 0; h < 2; h++) begin
         for (int a = 0; a < 4; a++) begin
            tt = 1'($urandom % 2);
            wb(1, REG_CFG0, {30'h0, h[0], 1'b0});
            wb(1, REG_CFG2, {28'h0, tt, 1'b0, a[1:0]});
            repeat (4) @(posedge clk_i);
            e.lp_freeze = (a == 1) || (a == 2);
            e.hp_quiet_ground = (a == 1);
            e.hp_tc_div = a[1] ? (h[0] ? 5'h08 : 5'h10) : 5'h01;
            e.hp2_quiet_ground = (a == 3);
            e.threshold_track = tt;
            check(32'(filt_o), 32'(e), 0);
         end
      end
      // Page 0 written over the serial link
      host.send(8'h43, 8);
      wb(0, REG_CFG0, 32'h03);
      // Page 2 written over the serial link, low bit alone first
      host.send(8'h61, 8);
      repeat (10) @(posedge clk_i);
      e = '{1'b1, 1'b1, 5'h01, 1'b0, 1'b0};
      check(32'(filt_o), 32'(e), 0);
      host.send(8'h6b, 8);
      repeat (10) @(posedge clk_i);
      e = '{1'b0, 1'b0, 5'h08, 1'b1, 1'b1};
      check(32'(filt_o), 32'(e), 0);
      wb(0, REG_CFG2, 32'h0b);
      finish_test();
   end
endmodule
